// file: tlm_mission_status.sv
// Notes on behaviour
// - logging enable arms mission, log from 1000h
// - format bit picks one or two bytes
// - two-byte: upper byte at lower address
// - rollover wraps pointer to datalog start
// - no rollover: halt when full, stay active
// - start-on-alarm waits for alarm conversion
// - trigger reading logged, counter not bumped
// - alarm flags read-only, fixed bits
// - clear memory clears all alarm flags
// - temp alarms gated, battery alarm always
// - battery reset sets battery flag
// - low flag on reading at/below threshold
// - high flag on reading at/above threshold
// - forced and trigger conversions set flags
// - state flags read-only, fixed bits
// - active flag high during mission
// - clear memory sets cleared, start clears it
// - start only after memory cleared
// - waiting flag set on start if start-on-alarm, cleared alarm
// - stop keeps waiting flag set
// - sensor enables gate low and high flags
// - compare upper byte only
// - setup bits 7,6 read one; bit 1 zero
`timescale 1ns/1ps
`default_nettype none
module tlm_mission_status #(
  parameter int LOG_BYTES = 8192
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // battery power-on reset indication (asynchronous pin)
  input  wire logic        battery_por,
  // register access port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // commands, one-cycle pulses
  input  wire logic        cmd_clear_mem,
  input  wire logic        cmd_start,
  input  wire logic        cmd_stop,
  // conversion results from the sampling path
  input  wire logic        conv_done,
  input  wire logic        conv_forced,
  input  wire logic [15:0] conv_value,
  // sample-rate tick from the real-time clock
  input  wire logic        sample_tick,
  // conversion request to the sensor
  output logic             conv_req,
  output logic             conv_wide,
  // datalog write
  output logic             log_we,
  output logic      [15:0] log_addr,
  output logic      [7:0]  log_data,
  // status outputs
  output logic             mission_active,
  output logic             sample_count_inc
);
  localparam logic [15:0] LOG_LAST = 16'(LOG_BYTES - 1);

  typedef enum logic [1:0] {
    TLM_IDLE,
    TLM_WAIT_ALARM,
    TLM_LOGGING,
    TLM_HALTED
  } tlm_state_t;

  tlm_state_t  state_q;
  logic [7:0]  setup_q;
  logic [7:0]  sens_q;
  logic [7:0]  low_thr_q;
  logic [7:0]  high_thr_q;
  logic        low_flag_q;
  logic        high_flag_q;
  logic        bat_flag_q;
  logic        active_q;
  logic        cleared_q;
  logic        wait_q;
  logic [15:0] ptr_q;
  logic        second_q;
  logic [7:0]  low_byte_q;
  logic        conv_pend_q;
  logic        por_s1_q;
  logic        por_s2_q;
  logic        por_s3_q;
  logic        low_hit;
  logic        high_hit;
  logic        mission_conv;
  logic        start_ok;
  logic        fmt_wide;
  logic        log_sample;
  logic        trig;
  logic        log_full;

  tlm_alarm_cmp u_cmp (
    .sample_msb  (conv_value[15:8]),
    .low_thresh  (low_thr_q),
    .high_thresh (high_thr_q),
    .low_en      (sens_q[tlm_pkg::SENS_LOW_EN]),
    .high_en     (sens_q[tlm_pkg::SENS_HIGH_EN]),
    .low_hit     (low_hit),
    .high_hit    (high_hit)
  );

  assign start_ok     = cmd_start && cleared_q && !active_q;
  assign fmt_wide     = setup_q[tlm_pkg::SETUP_FMT];
  // forced conversions only touch flags, never the datalog
  assign mission_conv = conv_done && !conv_forced && (state_q == TLM_WAIT_ALARM || state_q == TLM_LOGGING);
  assign trig         = mission_conv && (state_q == TLM_WAIT_ALARM) && (low_hit || high_hit);
  assign log_sample   = (mission_conv && state_q == TLM_LOGGING) || trig;
  // last datalog byte written without rollover
  assign log_full     = !setup_q[tlm_pkg::SETUP_ROLL] && (ptr_q == LOG_LAST) && (second_q || log_sample);

  // battery reset pin synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      por_s3_q <= 1'b0;
    end else begin
      por_s1_q <= battery_por;
      por_s2_q <= por_s1_q;
      por_s3_q <= por_s2_q;
    end
  end

  // writable configuration, locked during a mission
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      setup_q    <= tlm_pkg::SETUP_RESET;
      sens_q     <= 8'h00;
      low_thr_q  <= tlm_pkg::THRESH_RESET;
      high_thr_q <= tlm_pkg::THRESH_RESET;
    end else if (reg_wr && !active_q) begin
      if (reg_addr == tlm_pkg::ADDR_MISSION_SETUP) begin
        // fixed ones, bit 1 forced zero
        setup_q <= (reg_wdata & tlm_pkg::SETUP_WR_MASK) | tlm_pkg::SETUP_FIXED_ONES;
      end else if (reg_addr == tlm_pkg::ADDR_SENSOR_CTRL) begin
        sens_q <= reg_wdata & tlm_pkg::SENS_WR_MASK;
      end else if (reg_addr == tlm_pkg::ADDR_LOW_THRESH) begin
        low_thr_q <= reg_wdata;
      end else if (reg_addr == tlm_pkg::ADDR_HIGH_THRESH) begin
        high_thr_q <= reg_wdata;
      end
    end
  end

  // alarm flags; a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_flag_q  <= 1'b0;
      high_flag_q <= 1'b0;
      bat_flag_q  <= 1'b0;
    end else begin
      if (cmd_clear_mem && !active_q) begin
        low_flag_q  <= 1'b0;
        high_flag_q <= 1'b0;
        bat_flag_q  <= 1'b0;
      end
      if ((mission_conv || (conv_done && conv_forced)) && low_hit) begin
        low_flag_q <= 1'b1;
      end
      if ((mission_conv || (conv_done && conv_forced)) && high_hit) begin
        high_flag_q <= 1'b1;
      end
      if (por_s2_q && !por_s3_q) begin
        bat_flag_q <= 1'b1;
      end
    end
  end

  // mission state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= TLM_IDLE;
    end else begin
      case (state_q)
        TLM_IDLE: begin
          if (start_ok && setup_q[tlm_pkg::SETUP_LOG_EN]) begin
            state_q <= setup_q[tlm_pkg::SETUP_SOA] ? TLM_WAIT_ALARM : TLM_LOGGING;
          end
        end
        TLM_WAIT_ALARM: begin
          if (cmd_stop) begin
            state_q <= TLM_IDLE;
          end else if (trig) begin
            state_q <= TLM_LOGGING;
          end
        end
        TLM_LOGGING: begin
          if (cmd_stop) begin
            state_q <= TLM_IDLE;
          end else if (log_full) begin
            state_q <= TLM_HALTED;
          end
        end
        TLM_HALTED: begin
          if (cmd_stop) begin
            state_q <= TLM_IDLE;
          end
        end
        default: state_q <= TLM_IDLE;
      endcase
    end
  end

  // mission state flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_q  <= 1'b0;
      cleared_q <= 1'b0;
      wait_q    <= 1'b0;
    end else begin
      if (start_ok) begin
        active_q <= 1'b1;
      end else if (cmd_stop) begin
        active_q <= 1'b0;
      end
      if (start_ok) begin
        cleared_q <= 1'b0;
      end else if (cmd_clear_mem && !active_q) begin
        cleared_q <= 1'b1;
      end
      if (start_ok && setup_q[tlm_pkg::SETUP_SOA] && setup_q[tlm_pkg::SETUP_LOG_EN]) begin
        wait_q <= 1'b1;
      end else if (trig || (conv_done && conv_forced && (low_hit || high_hit))) begin
        wait_q <= 1'b0;
      end
    end
  end

  // datalog pointer and writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ptr_q      <= 16'h0000;
      second_q   <= 1'b0;
      low_byte_q <= 8'h00;
      log_we     <= 1'b0;
      log_addr   <= tlm_pkg::LOG_BASE_ADDR;
      log_data   <= 8'h00;
    end else begin
      log_we <= 1'b0;
      if (start_ok) begin
        ptr_q    <= 16'h0000;
        second_q <= 1'b0;
      end else if (second_q) begin
        log_we   <= 1'b1;
        log_addr <= tlm_pkg::LOG_BASE_ADDR + ptr_q;
        log_data <= low_byte_q;
        second_q <= 1'b0;
        ptr_q    <= (ptr_q == LOG_LAST) ? 16'h0000 : ptr_q + 16'h0001;
      end else if (log_sample) begin
        log_we     <= 1'b1;
        log_addr   <= tlm_pkg::LOG_BASE_ADDR + ptr_q;
        log_data   <= conv_value[15:8];
        low_byte_q <= conv_value[7:0];
        // one or two bytes per reading
        // a lower byte that would wrap a full datalog is dropped
        second_q   <= fmt_wide && !trig && !(ptr_q == LOG_LAST && !setup_q[tlm_pkg::SETUP_ROLL]);
        ptr_q      <= (ptr_q == LOG_LAST) ? 16'h0000 : ptr_q + 16'h0001;
      end
    end
  end

  // conversion requests and sample counting
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      conv_req         <= 1'b0;
      conv_wide        <= 1'b0;
      conv_pend_q      <= 1'b0;
      sample_count_inc <= 1'b0;
      mission_active   <= 1'b0;
    end else begin
      mission_active <= active_q;
      conv_req       <= 1'b0;
      // one conversion in flight at a time
      // no conversions after halt
      if (sample_tick && (state_q == TLM_WAIT_ALARM || state_q == TLM_LOGGING) && !conv_pend_q) begin
        conv_req    <= 1'b1;
        conv_pend_q <= 1'b1;
        conv_wide   <= (state_q == TLM_LOGGING) && fmt_wide;
      end else if (conv_done && !conv_forced) begin
        conv_pend_q <= 1'b0;
      end
      sample_count_inc <= mission_conv && (state_q == TLM_LOGGING);
    end
  end

  // register read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == tlm_pkg::ADDR_ALARM_FLAGS) begin
        reg_rdata <= tlm_pkg::ALM_FIXED_ONES | {bat_flag_q, 5'h00, high_flag_q, low_flag_q};
      end else if (reg_addr == tlm_pkg::ADDR_STATE_FLAGS) begin
        reg_rdata <= tlm_pkg::ST_FIXED_ONES | {3'h0, wait_q, cleared_q, 1'b0, active_q, 1'b0};
      end else if (reg_addr == tlm_pkg::ADDR_MISSION_SETUP) begin
        reg_rdata <= setup_q;
      end else if (reg_addr == tlm_pkg::ADDR_SENSOR_CTRL) begin
        reg_rdata <= sens_q;
      end else if (reg_addr == tlm_pkg::ADDR_LOW_THRESH) begin
        reg_rdata <= low_thr_q;
      end else if (reg_addr == tlm_pkg::ADDR_HIGH_THRESH) begin
        reg_rdata <= high_thr_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule : tlm_mission_status
`default_nettype wire

// file: tlm_pkg.sv
`default_nettype none
package tlm_pkg;
  // register addresses
  localparam logic [15:0] ADDR_SENSOR_CTRL  = 16'h0210;
  localparam logic [15:0] ADDR_MISSION_SETUP = 16'h0213;
  localparam logic [15:0] ADDR_ALARM_FLAGS  = 16'h0214;
  localparam logic [15:0] ADDR_STATE_FLAGS  = 16'h0215;
  localparam logic [15:0] ADDR_LOW_THRESH   = 16'h0208;
  localparam logic [15:0] ADDR_HIGH_THRESH  = 16'h0209;
  // datalog
  localparam logic [15:0] LOG_BASE_ADDR     = 16'h1000;
  localparam int          LOG_ADDR_W        = 13;
  // mission setup field positions
  localparam int SETUP_LOG_EN   = 0;
  localparam int SETUP_FMT      = 2;
  localparam int SETUP_ROLL     = 4;
  localparam int SETUP_SOA      = 5;
  localparam logic [7:0] SETUP_FIXED_ONES = 8'hC0;
  localparam logic [7:0] SETUP_WR_MASK    = 8'h3D;
  localparam logic [7:0] SETUP_RESET      = 8'hC0;
  // alarm flags field positions
  localparam int ALM_LOW  = 0;
  localparam int ALM_HIGH = 1;
  localparam int ALM_BAT  = 7;
  localparam logic [7:0] ALM_FIXED_ONES   = 8'h70;
  // state flags field positions
  localparam int ST_ACTIVE  = 1;
  localparam int ST_CLEARED = 3;
  localparam int ST_WAIT    = 4;
  localparam logic [7:0] ST_FIXED_ONES    = 8'hC0;
  // sensor control
  localparam int SENS_LOW_EN  = 0;
  localparam int SENS_HIGH_EN = 1;
  localparam logic [7:0] SENS_WR_MASK = 8'h03;
  // thresholds after reset
  localparam logic [7:0] THRESH_RESET = 8'h00;
  // conversion kinds
  typedef enum logic [1:0] {
    TLM_CONV_MISSION,
    TLM_CONV_FORCED
  } tlm_conv_t;
endpackage : tlm_pkg
`default_nettype wire

// file: tlm_alarm_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// compares the reading's upper byte against both thresholds
module tlm_alarm_cmp (
  // reading and thresholds
  input  wire logic [7:0] sample_msb,
  input  wire logic [7:0] low_thresh,
  input  wire logic [7:0] high_thresh,
  // enables
  input  wire logic       low_en,
  input  wire logic       high_en,
  // results
  output logic            low_hit,
  output logic            high_hit
);
  assign low_hit  = low_en && (sample_msb <= low_thresh);
  assign high_hit = high_en && (sample_msb >= high_thresh);
endmodule : tlm_alarm_cmp
`default_nettype wire

// file: tlm_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module tlm_status_props #(
  parameter int LOG_BYTES = 8192
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // commands and conversions
  input wire logic        cmd_stop,
  input wire logic        conv_done,
  input wire logic        conv_req,
  // datalog and status
  input wire logic        log_we,
  input wire logic [15:0] log_addr,
  input wire logic        mission_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence rd_of(logic [15:0] a);
    reg_rd && reg_addr == a ##1 1'h1;
  endsequence
  reset_state_a: assert property (
    $fell(sys_rst) |-> log_addr == 16'h1000 && !log_we && !mission_active)
    else $error("outputs wrong after reset");
  alarm_fixed_a: assert property (
    rd_of(tlm_pkg::ADDR_ALARM_FLAGS) |-> reg_rdata[6:2] == 5'h1C)
    else $error("alarm fixed bits wrong");
  state_fixed_a: assert property (
    rd_of(tlm_pkg::ADDR_STATE_FLAGS) |-> reg_rdata[7:5] == 3'h6 && !reg_rdata[2] && !reg_rdata[0])
    else $error("state fixed bits wrong");
  setup_fixed_a: assert property (
    rd_of(tlm_pkg::ADDR_MISSION_SETUP) |-> reg_rdata[7:6] == 2'h3 && !reg_rdata[1])
    else $error("setup fixed bits wrong");
  log_window_a: assert property (
    log_we |-> log_addr >= tlm_pkg::LOG_BASE_ADDR && log_addr < tlm_pkg::LOG_BASE_ADDR + LOG_BYTES)
    else $error("log write outside datalog");
  log_step_a: assert property (
    log_we && $past(log_we) |-> log_addr == $past(log_addr) + 16'h1 || log_addr == tlm_pkg::LOG_BASE_ADDR)
    else $error("log address did not step");
  log_cause_a: assert property (
    log_we |-> $past(conv_done) || $past(conv_done, 2))
    else $error("log write without conversion");
  stop_ends_a: assert property (
    cmd_stop |=> ##1 !mission_active)
    else $error("mission still active after stop");
  conv_idle_a: assert property (
    conv_req |-> mission_active)
    else $error("conversion request outside mission");
endmodule : tlm_status_props
bind tlm_mission_status tlm_status_props #(.LOG_BYTES(LOG_BYTES)) u_props (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmd_stop(cmd_stop), .conv_done(conv_done), .conv_req(conv_req),
  .log_we(log_we), .log_addr(log_addr), .mission_active(mission_active));
`default_nettype wire

// file: tlm_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlm_sensor_model #(
  parameter int DELAY = 3
) (
  // clock
  input wire logic         clock,
  // requests
  input wire logic         conv_req,
  input wire logic         force_conv,
  input wire logic [15:0]  reading,
  // results
  output var logic         conv_done,
  output var logic         conv_forced,
  output var logic [15:0]  conv_value
);
  int cnt_q = 0;
  initial conv_value = 16'h5A5A;
  // value is only valid with the done pulse, so it churns otherwise
  always @(posedge clock) begin
    conv_done <= 1'h0;
    conv_forced <= 1'h0;
    conv_value <= ~conv_value;
    if (conv_req)
      cnt_q <= DELAY;
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
    if (cnt_q == 1 || force_conv) begin
      conv_done <= 1'h1;
      conv_forced <= force_conv;
      conv_value <= reading;
    end
  end
endmodule : tlm_sensor_model
`default_nettype wire

// file: tlm_mission_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin got_v = (g); exp_v = (e); checks_done++; if (got_v !== exp_v) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, got_v, exp_v); end end
module tlm_mission_status_bench;
  logic clock = 1'h0, sys_rst = 1'h1, battery_por = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0;
  logic cmd_clear_mem = 1'h0, cmd_start = 1'h0, cmd_stop = 1'h0, sample_tick = 1'h0, force_conv = 1'h0;
  logic [15:0] reg_addr = 16'h0, reading = 16'h0, conv_value, log_addr;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, log_data, msb;
  logic conv_done, conv_forced, conv_req, conv_wide, log_we, mission_active, sample_count_inc;
  logic [23:0] got_v, exp_v, lq[$], rq[$];
  logic exp_wide = 1'h0;
  logic [23:0] inc_cnt = 24'h0, req_cnt = 24'h0;
  int error_cnt = 0, checks_done = 0, seed = 32'h4311;
  always #4 clock = ~clock;
  tlm_mission_status #(.LOG_BYTES(8)) dut (.clock(clock), .sys_rst(sys_rst), .battery_por(battery_por),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmd_clear_mem(cmd_clear_mem), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .conv_done(conv_done),
    .conv_forced(conv_forced), .conv_value(conv_value), .sample_tick(sample_tick), .conv_req(conv_req),
    .conv_wide(conv_wide), .log_we(log_we), .log_addr(log_addr), .log_data(log_data),
    .mission_active(mission_active), .sample_count_inc(sample_count_inc));
  tlm_sensor_model #(.DELAY(3)) sensor (.clock(clock), .conv_req(conv_req), .force_conv(force_conv),
    .reading(reading), .conv_done(conv_done), .conv_forced(conv_forced), .conv_value(conv_value));
  // watches read data and datalog writes against the oldest note
  always @(posedge clock) begin
    if (rd_d)
      `CHK(reg_rdata, rq.size() ? rq.pop_front() : 24'hX)
    rd_d <= reg_rd;
    if (log_we)
      `CHK({log_addr, log_data}, lq.size() ? lq.pop_front() : 24'hX)
    if (conv_req)
      `CHK(conv_wide, exp_wide)
    if (conv_req)
      req_cnt <= req_cnt + 24'h1;
    if (sample_count_inc)
      inc_cnt <= inc_cnt + 24'h1;
  end
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
    @(negedge clock);
    reg_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    rq.push_back({16'h0, e});
    {reg_addr, reg_rd} = {a, 1'h1};
    @(negedge clock);
    reg_rd = 1'h0;
    @(negedge clock);
  endtask : rd
  task automatic cmd(input logic [2:0] c);
    @(negedge clock);
    {cmd_clear_mem, cmd_start, cmd_stop} = c;
    @(negedge clock);
    {cmd_clear_mem, cmd_start, cmd_stop} = 3'h0;
    repeat (3) @(negedge clock);
  endtask : cmd
  // one sample tick or forced conversion, then every noted write must have landed
  task automatic sample(input logic [15:0] v, input logic forced);
    @(negedge clock);
    reading = v;
    {sample_tick, force_conv} = {~forced, forced};
    @(negedge clock);
    {sample_tick, force_conv} = 2'h0;
    repeat (12) @(negedge clock);
    if (lq.size()) begin
      error_cnt++;
      summarize();
    end
  endtask : sample
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'h0;
    rd(tlm_pkg::ADDR_MISSION_SETUP, 8'hC0);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC0);
    wr(tlm_pkg::ADDR_ALARM_FLAGS, 8'hFF);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h70);
    rd(16'h0300, 8'h00);
    cmd(3'h2);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC0);
    @(negedge clock);
    battery_por = 1'h1;
    repeat (4) @(negedge clock);
    battery_por = 1'h0;
    repeat (6) @(negedge clock);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'hF0);
    cmd(3'h4);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h70);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC8);
    wr(tlm_pkg::ADDR_LOW_THRESH, 8'h20);
    wr(tlm_pkg::ADDR_HIGH_THRESH, 8'h80);
    wr(tlm_pkg::ADDR_SENSOR_CTRL, 8'h03);
    wr(tlm_pkg::ADDR_MISSION_SETUP, 8'h17);
    rd(tlm_pkg::ADDR_MISSION_SETUP, 8'hD5);
    cmd(3'h2);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC2);
    wr(tlm_pkg::ADDR_MISSION_SETUP, 8'h00);
    rd(tlm_pkg::ADDR_MISSION_SETUP, 8'hD5);
    exp_wide = 1'h1;
    // two-byte entries wrap, boundary readings at both thresholds
    for (int i = 0; i < 7; i++) begin
      got_v = 24'($random(seed));
      msb = (i == 5) ? 8'h80 : (i == 6) ? 8'h20 : {2'h1, got_v[5:0]};
      lq.push_back({16'h1000 + 16'((2 * i) % 8), msb});
      lq.push_back({16'h1000 + 16'((2 * i + 1) % 8), got_v[15:8]});
      sample({msb, got_v[15:8]}, 1'h0);
    end
    `CHK(inc_cnt, 24'h7)
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h73);
    cmd(3'h1);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC0);
    cmd(3'h4);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h70);
    wr(tlm_pkg::ADDR_SENSOR_CTRL, 8'h01);
    wr(tlm_pkg::ADDR_MISSION_SETUP, 8'h21);
    cmd(3'h2);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hD2);
    exp_wide = 1'h0;
    sample(16'h9000, 1'h0);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h70);
    // trigger logged first, one-byte entries, halt when full
    for (int i = 0; i < 9; i++) begin
      got_v = 24'($random(seed));
      msb = (i == 0) ? 8'h20 : {2'h1, got_v[5:0]};
      if (i < 8)
        lq.push_back({16'h1000 + 16'(i), msb});
      sample({msb, got_v[15:8]}, 1'h0);
    end
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h71);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC2);
    `CHK(inc_cnt, 24'hE)
    `CHK(req_cnt, 24'h10)
    cmd(3'h1);
    cmd(3'h4);
    wr(tlm_pkg::ADDR_SENSOR_CTRL, 8'h03);
    wr(tlm_pkg::ADDR_MISSION_SETUP, 8'h25);
    cmd(3'h2);
    sample(16'h5000, 1'h0);
    cmd(3'h1);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hD0);
    // lowest high threshold plus forced conversion
    wr(tlm_pkg::ADDR_HIGH_THRESH, 8'h00);
    sample(16'h5000, 1'h1);
    rd(tlm_pkg::ADDR_STATE_FLAGS, 8'hC0);
    rd(tlm_pkg::ADDR_ALARM_FLAGS, 8'h72);
    `CHK(req_cnt, 24'h11)
    if (rq.size())
      error_cnt++;
    summarize();
  end
endmodule : tlm_mission_status_bench
`default_nettype wire
